// *** bench/rcss_core_model.sv ***
`timescale 1ns/100ps
module rcss_core_model (
  input  wire logic        mclk,
  input  wire logic        core_reset_n,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_value,
  output logic      [15:0] last_pc  = 16'hFFFF,
  output logic      [7:0]  restarts = 8'h00
);
  logic run_q = 1'b0;

  // Core fetches from wherever the sequencer points it
  always @(posedge mclk)
  begin
    run_q <= core_reset_n;
    if (pc_load)
      last_pc <= pc_value;
    if (core_reset_n && !run_q)
      restarts <= restarts + 8'h01;
  end
endmodule : rcss_core_model

// *** bench/rcss_top_sva.sv ***
`timescale 1ns/100ps
module rcss_top_chk
  import rcss_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RESET_N,
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [1:0]  AVS_RESPONSE,
  input wire logic        CORE_RESET_N,
  input wire logic        PC_LOAD,
  input wire logic [15:0] PC_VALUE,
  input wire logic        PUSH_RETURN,
  input wire logic        WAKE_RESUME,
  input wire logic        PIN_GENERAL_INPUT,
  input wire logic        CPU_SLEEPING,
  input wire logic        WDT_TIMEOUT,
  input wire logic        RESET_INSTR,
  input wire logic        INTERRUPT_WAKE,
  input wire logic        GLOBAL_INTERRUPT_ENABLE,
  input wire logic        PROG_MODE_EXIT
);
  logic calm;

  // Higher-priority sources absent, so the event under test must win
  assign calm = CORE_RESET_N && PIN_GENERAL_INPUT && !PROG_MODE_EXIT;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus answer late");
  chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  chk_unmapped_err: assert property (AVS_READ && AVS_WAITREQUEST
    && AVS_ADDRESS > REG_SEQ_OFF |=> AVS_RESPONSE == RESP_SLVERR
    && AVS_READDATA == 32'h0) else $error("unmapped read answered");
  chk_wdt_reset: assert property (calm && WDT_TIMEOUT && !CPU_SLEEPING
    |=> !CORE_RESET_N) else $error("watchdog did not reset");
  chk_instr_reset: assert property (calm && RESET_INSTR && !CPU_SLEEPING
    && !WDT_TIMEOUT |=> !CORE_RESET_N) else $error("reset instr ignored");
  chk_sleep_wdt: assert property (calm && WDT_TIMEOUT && CPU_SLEEPING
    |=> CORE_RESET_N && WAKE_RESUME && !PUSH_RETURN)
    else $error("sleep watchdog wrong");
  chk_wake_vector: assert property (calm && CPU_SLEEPING && INTERRUPT_WAKE
    && !WDT_TIMEOUT && GLOBAL_INTERRUPT_ENABLE |=> WAKE_RESUME && PUSH_RETURN
    && PC_LOAD && PC_VALUE == INTERRUPT_VECTOR) else $error("wake vector wrong");
  chk_start_vector: assert property ($rose(CORE_RESET_N)
    |-> PC_LOAD && PC_VALUE == RESET_VECTOR) else $error("restart not at zero");
  chk_pin_hold: assert property (!PIN_GENERAL_INPUT |=> !CORE_RESET_N)
    else $error("pin low but core runs");
  chk_pin_delay: assert property ($rose(PIN_GENERAL_INPUT) && !CORE_RESET_N
    |-> !CORE_RESET_N [*8] ##[1:4] CORE_RESET_N) else $error("start delay wrong");
endmodule : rcss_top_chk

bind rcss_top rcss_top_chk rcss_top_chk_inst (
  .MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
  .CORE_RESET_N(CORE_RESET_N), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
  .PUSH_RETURN(PUSH_RETURN), .WAKE_RESUME(WAKE_RESUME),
  .PIN_GENERAL_INPUT(PIN_GENERAL_INPUT), .CPU_SLEEPING(CPU_SLEEPING),
  .WDT_TIMEOUT(WDT_TIMEOUT), .RESET_INSTR(RESET_INSTR),
  .INTERRUPT_WAKE(INTERRUPT_WAKE), .PROG_MODE_EXIT(PROG_MODE_EXIT),
  .GLOBAL_INTERRUPT_ENABLE(GLOBAL_INTERRUPT_ENABLE));

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench
  import rcss_pkg::*;
;
  logic        clk, rst_n, por, bor, pin_n, osc, sleep, global_interrupt_enable, rd, wr;
  logic        waitreq, core_n, pc_load, push, wake, gpin, sben;
  logic [6:0]  ev;
  logic [7:0]  addr, restarts;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  resp, r;
  logic [15:0] pc_val, last_pc;
  int          miscompares, checks, n;

  rcss_top #(.POWERUP_DELAY_TIMER_CYCLES(20), .FILTER_CYCLES(4)) rcss_top_inst (
    .MCLK(clk), .RESET_N(rst_n), .POR_ACTIVE(por), .BOR_ACTIVE(bor),
    .EXTERNAL_RESET_PIN_N(pin_n), .BROWNOUT_CIRCUIT_READY(1'b1),
    .OSC_STARTUP_DONE(osc), .PROG_MODE_EXIT(ev[5]), .WDT_TIMEOUT(ev[0]),
    .WDT_WINDOW_VIOLATION(ev[1]), .RESET_INSTR(ev[2]),
    .STACK_OVERFLOW(ev[3]), .STACK_UNDERFLOW(ev[4]), .CPU_SLEEPING(sleep),
    .INTERRUPT_WAKE(ev[6]), .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .AVS_RESPONSE(resp), .CORE_RESET_N(core_n), .PC_LOAD(pc_load),
    .PC_VALUE(pc_val), .PUSH_RETURN(push), .WAKE_RESUME(wake),
    .PIN_GENERAL_INPUT(gpin), .SOFTWARE_BROWNOUT_ENABLE(sben));

  rcss_core_model rcss_core_model_inst (.mclk(clk), .core_reset_n(core_n),
    .pc_load(pc_load), .pc_value(pc_val), .last_pc(last_pc),
    .restarts(restarts));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitreq !== 1'b0 && k < 50);
    check("bus answer", 32'(k < 50), 32'h1);
    q = rdata;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, q, e);
  endtask : rdchk

  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
  endtask : pulse

  task automatic wait_core(input logic lvl, input int lim);
    n = 0;
    while (core_n !== lvl && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check("core reset", 32'(core_n), 32'(lvl));
  endtask : wait_core

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk("cause", REG_CAUSE_OFF, 32'h3C);
    rdchk("status", REG_STATUS_OFF, 32'h18);
    rdchk("config", REG_CONFIG_OFF, 32'h5);
    rdchk("seq", REG_SEQ_OFF, 32'h10);
    rdchk("borctl", REG_BORCTL_OFF, 32'h81);
    bus(1'b1, REG_STATUS_OFF, 32'h0);
    rdchk("status ro", REG_STATUS_OFF, 32'h18);
    bus(1'b1, REG_BORCTL_OFF, 32'h0);
    repeat (2) @(posedge clk);
    check("sben", 32'(sben), 32'h0);
    bus(1'b1, REG_BORCTL_OFF, 32'h80);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
    check("unmapped data", q, 32'h0);
    bus(1'b1, 8'h40, 32'hFF);
    check("unmapped wr", 32'(r), 32'(RESP_SLVERR));
    $display("test regs done");
  endtask : t_regs

  task automatic t_sleep;
    sleep <= 1'b1;
    global_interrupt_enable   <= 1'b1;
    pulse(7'h40);
    @(posedge clk);
    check("push", 32'({wake, push, pc_val}), 32'h3_0004);
    rdchk("status", REG_STATUS_OFF, 32'h10);
    global_interrupt_enable <= 1'b0;
    pulse(7'h40);
    @(posedge clk);
    check("no push", 32'({wake, push}), 32'h2);
    pulse(7'h01);
    @(posedge clk);
    check("wdt wake", 32'({wake, core_n}), 32'h3);
    rdchk("status", REG_STATUS_OFF, 32'h00);
    pin_n <= 1'b0;
    wait_core(1'b0, 50);
    sleep <= 1'b0;
    pin_n <= 1'b1;
    wait_core(1'b1, 100);
    rdchk("cause", REG_CAUSE_OFF, 32'h34);
    rdchk("status", REG_STATUS_OFF, 32'h10);
    check("pc", 32'(last_pc), 32'h0);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_events;
    logic [6:0] m[6];
    logic [7:0] e[6];
    logic [7:0] k;
    m = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20};
    e = '{8'h2F, 8'h0F, 8'h3B, 8'hBF, 8'h7F, 8'h3D};
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, REG_CAUSE_OFF, 32'h3F);
      k = restarts;
      pulse(m[i]);
      wait_core(1'b0, 4);
      wait_core(1'b1, 200);
      rdchk("cause", REG_CAUSE_OFF, 32'(e[i]));
      check("restart", 32'(restarts), 32'(k + 8'h01));
      check("pc", 32'(last_pc), 32'h0);
    end
    bus(1'b1, REG_CONFIG_OFF, 32'h4);
    bus(1'b1, REG_CAUSE_OFF, 32'hFF);
    pulse(7'h08);
    repeat (20) @(posedge clk);
    check("gated", 32'(core_n), 32'h1);
    rdchk("cause", REG_CAUSE_OFF, 32'hFF);
    bus(1'b1, REG_CONFIG_OFF, 32'hD);
    osc <= 1'b0;
    pulse(7'h04);
    repeat (40) @(posedge clk);
    check("osc hold", 32'(core_n), 32'h0);
    osc <= 1'b1;
    wait_core(1'b1, 30);
    bus(1'b1, REG_CONFIG_OFF, 32'h5);
    $display("test events done");
  endtask : t_events

  task automatic t_power;
    bus(1'b1, REG_CAUSE_OFF, 32'hFF);
    por <= 1'b1;
    repeat (40) @(posedge clk);
    check("por hold", 32'(core_n), 32'h0);
    por <= 1'b0;
    wait_core(1'b1, 200);
    check("powerup_delay_timer", 32'(n >= 30 && n <= 60), 32'h1);
    rdchk("cause", REG_CAUSE_OFF, 32'h3D);
    rdchk("status", REG_STATUS_OFF, 32'h18);
    bus(1'b1, REG_CAUSE_OFF, 32'hFF);
    bor <= 1'b1;
    repeat (5) @(posedge clk);
    bor <= 1'b0;
    wait_core(1'b1, 200);
    rdchk("cause", REG_CAUSE_OFF, 32'h3E);
    $display("test power done");
  endtask : t_power

  task automatic t_pin;
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    pin_n <= 1'b1;
    repeat (20) @(posedge clk);
    check("glitch", 32'(core_n), 32'h1);
    bus(1'b1, REG_CAUSE_OFF, 32'h3F);
    pin_n <= 1'b0;
    wait_core(1'b0, 20);
    repeat (30) @(posedge clk);
    check("pin input", 32'({gpin, core_n}), 32'h0);
    pin_n <= 1'b1;
    wait_core(1'b1, 40);
    check("start delay", 32'(n >= 10 && n <= 20), 32'h1);
    rdchk("cause", REG_CAUSE_OFF, 32'h37);
    $display("test pin done");
  endtask : t_pin

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #500000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    {rst_n, por, bor, sleep, global_interrupt_enable, rd, wr, ev} = '0;
    {pin_n, osc} = 2'b11;
    addr  = 8'h00;
    wdata = 32'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wait_core(1'b1, 200);
    t_regs();
    t_sleep();
    t_events();
    t_power();
    t_pin();
    complete_run();
  end
endmodule : testbench

// *** shared/rcss_pkg.sv ***
package rcss_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] REG_CAUSE_OFF  = 8'h00;
  localparam logic [7:0] REG_BORCTL_OFF = 8'h04;
  localparam logic [7:0] REG_STATUS_OFF = 8'h08;
  localparam logic [7:0] REG_CONFIG_OFF = 8'h0C;
  localparam logic [7:0] REG_SEQ_OFF    = 8'h10;

  // Cause register fields
  localparam int CAUSE_STK_OVER   = 7;
  localparam int CAUSE_STK_UNDER  = 6;
  localparam int CAUSE_WIN_VIOL   = 5;
  localparam int CAUSE_WATCHDOG   = 4;
  localparam int CAUSE_PIN_RESET  = 3;
  localparam int CAUSE_RESET_INST = 2;
  localparam int CAUSE_POWER_ON   = 1;
  localparam int CAUSE_BROWNOUT   = 0;
  localparam logic [7:0] CAUSE_RESET = 8'h3C;

  // Brown-out control fields
  localparam int BORCTL_SW_ENABLE = 7;
  localparam int BORCTL_READY     = 0;
  localparam logic BORCTL_SW_ENABLE_RESET = 1'b1;

  // Core status fields
  localparam int STATUS_TIMEOUT   = 4;
  localparam int STATUS_POWERDOWN = 3;
  localparam logic STATUS_TIMEOUT_RESET   = 1'b1;
  localparam logic STATUS_POWERDOWN_RESET = 1'b1;

  // Configuration fields
  localparam int CFG_STACK_RESET_EN = 0;
  localparam int CFG_POWERUP_DELAY_TIMER_ENABLE_N  = 1;
  localparam int CFG_PIN_ENABLE     = 2;
  localparam int CFG_OST_REQUIRED   = 3;
  localparam logic [3:0] CFG_RESET  = 4'h5;

  // Vectors
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] INTERRUPT_VECTOR = 16'h0004;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_FREQ_HZ        = 100_000_000;
  localparam int POWERUP_DELAY_TIMER_TIME_MS       = 64;
  localparam int POWERUP_DELAY_TIMER_CYCLES_DEF    = POWERUP_DELAY_TIMER_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int START_DELAY_CYCLES = 10;
  localparam int PIN_FILTER_DEF     = 4;
  localparam int SEQ_CNT_W          = 23;

  typedef enum logic [4:0] {
    ST_HOLD  = 5'h01,
    ST_POWERUP_DELAY_TIMER  = 5'h02,
    ST_WAIT  = 5'h04,
    ST_DELAY = 5'h08,
    ST_RUN   = 5'h10
  } rcss_state_type;

endpackage : rcss_pkg

// *** verilog/rcss_top.sv ***
`timescale 1ns/100ps

module rcss_top
  import rcss_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_CYCLES   = POWERUP_DELAY_TIMER_CYCLES_DEF,
  parameter int FILTER_CYCLES = PIN_FILTER_DEF
)
(
  input  wire  logic        MCLK,
  input  wire  logic        RESET_N,
  input  wire  logic        POR_ACTIVE,
  input  wire  logic        BOR_ACTIVE,
  input  wire  logic        EXTERNAL_RESET_PIN_N,
  input  wire  logic        BROWNOUT_CIRCUIT_READY,
  input  wire  logic        OSC_STARTUP_DONE,
  input  wire  logic        PROG_MODE_EXIT,
  input  wire  logic        WDT_TIMEOUT,
  input  wire  logic        WDT_WINDOW_VIOLATION,
  input  wire  logic        RESET_INSTR,
  input  wire  logic        STACK_OVERFLOW,
  input  wire  logic        STACK_UNDERFLOW,
  input  wire  logic        CPU_SLEEPING,
  input  wire  logic        INTERRUPT_WAKE,
  input  wire  logic        GLOBAL_INTERRUPT_ENABLE,
  input  wire  logic [7:0]  AVS_ADDRESS,
  input  wire  logic        AVS_READ,
  input  wire  logic        AVS_WRITE,
  input  wire  logic [31:0] AVS_WRITEDATA,
  input  wire  logic [3:0]  AVS_BYTEENABLE,
  output logic       [31:0] AVS_READDATA,
  output logic              AVS_WAITREQUEST,
  output logic       [1:0]  AVS_RESPONSE,
  output logic              CORE_RESET_N,
  output logic              PC_LOAD,
  output logic       [15:0] PC_VALUE,
  output logic              PUSH_RETURN,
  output logic              WAKE_RESUME,
  output logic              PIN_GENERAL_INPUT,
  output logic              SOFTWARE_BROWNOUT_ENABLE
);

  localparam int FILT_W = $clog2(FILTER_CYCLES + 1);

  if (POWERUP_DELAY_TIMER_CYCLES < 1 || POWERUP_DELAY_TIMER_CYCLES >= (1 << SEQ_CNT_W))
  begin : g_bad_powerup_delay_timer
    $error("POWERUP_DELAY_TIMER_CYCLES out of range for the sequence counter");
  end
  if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255)
  begin : g_bad_filter
    $error("FILTER_CYCLES must lie between 1 and 255");
  end

  // Sync bit positions
  localparam int SY_POR = 0;
  localparam int SY_BOR = 1;
  localparam int SY_PIN = 2;
  localparam int SY_RDY = 3;

  localparam logic [SEQ_CNT_W-1:0] POWERUP_DELAY_TIMER_LAST  =
    SEQ_CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
  localparam logic [SEQ_CNT_W-1:0] DELAY_LAST =
    SEQ_CNT_W'(START_DELAY_CYCLES - 1);
  localparam logic [FILT_W-1:0]    FILT_LAST  =
    FILT_W'(FILTER_CYCLES - 1);

  typedef struct packed {
    rcss_state_type        state;
    logic [SEQ_CNT_W-1:0]  cnt;
    logic [3:0]            sync1;
    logic [3:0]            sync2;
    logic                  por_prev;
    logic                  bor_prev;
    logic [FILT_W-1:0]     filt_cnt;
    logic                  pin_filt;
    logic [7:0]            cause;
    logic                  timeout_bit;
    logic                  powerdown_bit;
    logic                  sw_bor_en;
    logic [3:0]            cfg;
    logic                  core_rst_n;
    logic                  pc_load;
    logic [15:0]           pc_val;
    logic                  push_ret;
    logic                  wake_res;
    logic                  gpio_in;
    logic                  waitreq;
    logic [31:0]           rdata;
    logic [1:0]            resp;
  } rcss_regs_type;

  localparam rcss_regs_type REGS_RESET = '{
    state:         ST_HOLD,
    cnt:           '0,
    sync1:         4'h0,
    sync2:         4'h0,
    por_prev:      1'b0,
    bor_prev:      1'b0,
    filt_cnt:      '0,
    pin_filt:      1'b1,
    cause:         CAUSE_RESET,
    timeout_bit:   STATUS_TIMEOUT_RESET,
    powerdown_bit: STATUS_POWERDOWN_RESET,
    sw_bor_en:     BORCTL_SW_ENABLE_RESET,
    cfg:           CFG_RESET,
    core_rst_n:    1'b0,
    pc_load:       1'b0,
    pc_val:        RESET_VECTOR,
    push_ret:      1'b0,
    wake_res:      1'b0,
    gpio_in:       1'b1,
    waitreq:       1'b1,
    rdata:         32'h0000_0000,
    resp:          RESP_OKAY
  };

  rcss_regs_type q;
  rcss_regs_type d;

  logic          por_act;
  logic          bor_act;
  logic          pin_rst;
  logic          osc_ok;
  logic          bus_req;
  logic          bus_take;
  logic          hit;
  logic          stack_en;

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction : addr_is

  function automatic logic addr_known(input logic [7:0] a);
    return addr_is(a, REG_CAUSE_OFF) || addr_is(a, REG_BORCTL_OFF) ||
           addr_is(a, REG_STATUS_OFF) || addr_is(a, REG_CONFIG_OFF) ||
           addr_is(a, REG_SEQ_OFF);
  endfunction : addr_known

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    d = q;

    // Two flops before anything reads these asynchronous levels
    d.sync1 = {BROWNOUT_CIRCUIT_READY, EXTERNAL_RESET_PIN_N,
               BOR_ACTIVE, POR_ACTIVE};
    d.sync2 = q.sync1;
    por_act = q.sync2[SY_POR];
    bor_act = q.sync2[SY_BOR];
    d.por_prev = por_act;
    d.bor_prev = bor_act;

    // Pin level must persist before the filtered copy follows it
    if (q.sync2[SY_PIN] == q.pin_filt)
    begin
      d.filt_cnt = '0;
    end
    else if (q.filt_cnt == FILT_LAST)
    begin
      d.pin_filt = q.sync2[SY_PIN];
      d.filt_cnt = '0;
    end
    else
    begin
      d.filt_cnt = q.filt_cnt + FILT_W'(1);
    end
    d.gpio_in = q.pin_filt;
    pin_rst   = q.cfg[CFG_PIN_ENABLE] & ~q.pin_filt;
    osc_ok    = OSC_STARTUP_DONE | ~q.cfg[CFG_OST_REQUIRED];
    stack_en  = q.cfg[CFG_STACK_RESET_EN];

    d.pc_load  = 1'b0;
    d.push_ret = 1'b0;
    d.wake_res = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, answer on the next edge

    bus_req   = AVS_READ | AVS_WRITE;
    bus_take  = bus_req & ~q.waitreq;
    hit       = addr_known(AVS_ADDRESS);
    d.waitreq = 1'b1;
    if (bus_req && q.waitreq)
    begin
      d.waitreq = 1'b0;
      d.resp    = hit ? RESP_OKAY : RESP_SLVERR;
      d.rdata   = 32'h0000_0000;
      if (AVS_READ)
      begin
        if (addr_is(AVS_ADDRESS, REG_CAUSE_OFF))
          d.rdata[7:0] = q.cause;
        else if (addr_is(AVS_ADDRESS, REG_BORCTL_OFF))
        begin
          d.rdata[BORCTL_SW_ENABLE] = q.sw_bor_en;
          d.rdata[BORCTL_READY]     = q.sync2[SY_RDY];
        end
        else if (addr_is(AVS_ADDRESS, REG_STATUS_OFF))
        begin
          d.rdata[STATUS_TIMEOUT]   = q.timeout_bit;
          d.rdata[STATUS_POWERDOWN] = q.powerdown_bit;
        end
        else if (addr_is(AVS_ADDRESS, REG_CONFIG_OFF))
          d.rdata[3:0] = q.cfg;
        else if (addr_is(AVS_ADDRESS, REG_SEQ_OFF))
          d.rdata[4:0] = q.state;
      end
    end

    // Software writes first; hardware events below override them
    if (bus_take && AVS_WRITE && AVS_BYTEENABLE[0])
    begin
      if (addr_is(AVS_ADDRESS, REG_CAUSE_OFF))
        d.cause = AVS_WRITEDATA[7:0];
      else if (addr_is(AVS_ADDRESS, REG_BORCTL_OFF))
        d.sw_bor_en = AVS_WRITEDATA[BORCTL_SW_ENABLE];
      else if (addr_is(AVS_ADDRESS, REG_CONFIG_OFF))
        d.cfg = AVS_WRITEDATA[3:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up and reset sequencer

    case (q.state)
      ST_HOLD:
      begin
        d.core_rst_n = 1'b0;
        d.cnt        = '0;
        if (!por_act && !bor_act)
        begin
          if (!q.cfg[CFG_POWERUP_DELAY_TIMER_ENABLE_N])
            d.state = ST_POWERUP_DELAY_TIMER;
          else
            d.state = ST_WAIT;
        end
      end
      ST_POWERUP_DELAY_TIMER:
      begin
        // Pin is not looked at here, so the delay runs under a held pin
        if (q.cnt == POWERUP_DELAY_TIMER_LAST)
          d.state = ST_WAIT;
        else
          d.cnt = q.cnt + SEQ_CNT_W'(1);
      end
      ST_WAIT:
      begin
        d.cnt = '0;
        if (osc_ok && !pin_rst)
          d.state = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (pin_rst)
          d.state = ST_WAIT;
        else if (q.cnt == DELAY_LAST)
        begin
          d.state      = ST_RUN;
          d.core_rst_n = 1'b1;
          d.pc_load    = 1'b1;
          d.pc_val     = RESET_VECTOR;
        end
        else
          d.cnt = q.cnt + SEQ_CNT_W'(1);
      end
      ST_RUN:
      begin
        if (pin_rst)
        begin
          d.cause[CAUSE_PIN_RESET] = 1'b0;
          if (CPU_SLEEPING)
          begin
            d.timeout_bit   = 1'b1;
            d.powerdown_bit = 1'b0;
          end
          d.state      = ST_WAIT;
          d.core_rst_n = 1'b0;
        end
        else if (CPU_SLEEPING)
        begin
          if (WDT_TIMEOUT)
          begin
            d.timeout_bit   = 1'b0;
            d.powerdown_bit = 1'b0;
            d.wake_res      = 1'b1;
          end
          else if (INTERRUPT_WAKE)
          begin
            d.timeout_bit   = 1'b1;
            d.powerdown_bit = 1'b0;
            d.wake_res      = 1'b1;
            if (GLOBAL_INTERRUPT_ENABLE)
            begin
              d.push_ret = 1'b1;
              d.pc_load  = 1'b1;
              d.pc_val   = INTERRUPT_VECTOR;
            end
          end
        end
        else if (WDT_WINDOW_VIOLATION)
        begin
          d.cause[CAUSE_WIN_VIOL] = 1'b0;
          d.cause[CAUSE_WATCHDOG] = 1'b0;
          d.timeout_bit           = 1'b0;
          d.state                 = ST_WAIT;
          d.core_rst_n            = 1'b0;
        end
        else if (WDT_TIMEOUT)
        begin
          d.cause[CAUSE_WATCHDOG] = 1'b0;
          d.timeout_bit           = 1'b0;
          d.state                 = ST_WAIT;
          d.core_rst_n            = 1'b0;
        end
        else if (RESET_INSTR)
        begin
          d.cause[CAUSE_RESET_INST] = 1'b0;
          d.state                   = ST_WAIT;
          d.core_rst_n              = 1'b0;
        end
        else if (STACK_OVERFLOW && stack_en)
        begin
          d.cause[CAUSE_STK_OVER] = 1'b1;
          d.state                 = ST_WAIT;
          d.core_rst_n            = 1'b0;
        end
        else if (STACK_UNDERFLOW && stack_en)
        begin
          d.cause[CAUSE_STK_UNDER] = 1'b1;
          d.state                  = ST_WAIT;
          d.core_rst_n             = 1'b0;
        end
      end
      default:
      begin
        d.state      = ST_HOLD;
        d.core_rst_n = 1'b0;
      end
    endcase

    // Supply events override the sequencer and any same-cycle write to the cause bits they set
    if ((por_act && !q.por_prev) || PROG_MODE_EXIT)
    begin
      d.cause = {2'b00, 4'hF, 1'b0, q.cause[CAUSE_BROWNOUT]};
      d.timeout_bit   = 1'b1;
      d.powerdown_bit = 1'b1;
      d.state         = ST_HOLD;
      d.core_rst_n    = 1'b0;
      d.pc_load       = 1'b0;
      d.push_ret      = 1'b0;
      d.wake_res      = 1'b0;
    end
    else if (bor_act && !q.bor_prev)
    begin
      d.cause[CAUSE_STK_OVER]   = 1'b0;
      d.cause[CAUSE_STK_UNDER]  = 1'b0;
      d.cause[CAUSE_PIN_RESET]  = 1'b1;
      d.cause[CAUSE_RESET_INST] = 1'b1;
      d.cause[CAUSE_BROWNOUT]   = 1'b0;
      d.timeout_bit             = 1'b1;
      d.powerdown_bit           = 1'b1;
      d.state                   = ST_HOLD;
      d.core_rst_n              = 1'b0;
      d.pc_load                 = 1'b0;
      d.push_ret                = 1'b0;
      d.wake_res                = 1'b0;
    end
    else if (por_act || bor_act)
    begin
      d.state      = ST_HOLD;
      d.core_rst_n = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      q <= REGS_RESET;
    else
      q <= d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign AVS_READDATA             = q.rdata;
  assign AVS_WAITREQUEST          = q.waitreq;
  assign AVS_RESPONSE             = q.resp;
  assign CORE_RESET_N             = q.core_rst_n;
  assign PC_LOAD                  = q.pc_load;
  assign PC_VALUE                 = q.pc_val;
  assign PUSH_RETURN              = q.push_ret;
  assign WAKE_RESUME              = q.wake_res;
  assign PIN_GENERAL_INPUT        = q.gpio_in;
  assign SOFTWARE_BROWNOUT_ENABLE = q.sw_bor_en;

endmodule : rcss_top
